// File: logic/pmw_pkg.sv
// pmw_pkg: constants shared by the paged memory-window mapper.
// assumes: imported by the decoder, translator and mapper files through pmw_pkg::*.
package pmw_pkg;

  localparam int unsigned PAGES_A = 8;
  localparam int unsigned PAGES_B = 4;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_ROMCFG = 10'h065;
  localparam logic [9:0] IDX_EXT_HI = 10'h067;
  localparam logic [9:0] IDX_EXT23 = 10'h06C;
  localparam logic [9:0] IDX_BASEIO = 10'h06D;
  localparam logic [9:0] IDX_EXT_LO = 10'h06E;
  localparam logic [9:0] IDX_SETB_CTL = 10'h074;

  // field positions
  localparam int unsigned ROMCFG_SETA_EN_BIT = 6;
  localparam int unsigned SETB_REGION_BIT = 1;
  localparam int unsigned SETB_EN_BIT = 0;
  localparam int unsigned PAGE_EN_BIT = 7;
  localparam int unsigned BASE_SEL_LSB = 4;
  localparam int unsigned IO_SEL_LSB = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // window geometry: set A base in 16-Kbyte blocks, set B base in 64-Kbyte units
  localparam logic [9:0] SETA_BASE_BLK = 10'h0030;
  localparam logic [7:0] SETB_BASE_HI = 8'h0A;

  // page-register I/O base for page 0; bit 13 is the valid flag
  function automatic logic [13:0] io_base(input logic [3:0] code);
    logic [13:0] r;
    case (code)
      4'h0: r = {1'b1, 13'h0208};
      4'h1: r = {1'b1, 13'h0218};
      4'h5: r = {1'b1, 13'h0258};
      4'h6: r = {1'b1, 13'h0268};
      4'hA: r = {1'b1, 13'h02A8};
      4'hB: r = {1'b1, 13'h02B8};
      4'hE: r = {1'b1, 13'h02E8};
      default: r = 14'h0000;
    endcase
    return r;
  endfunction : io_base

endpackage : pmw_pkg

// File: logic/pmw_map_if.sv
// pmw_map_if: mapping state handed from the register block to the
// translator. assumes: one driver (top), one reader (translator).
`timescale 1ns/10ps
interface pmw_map_if;
  logic [3:0] base_sel;
  logic set_a_en;
  logic set_b_en;
  logic [7:0] page_a [8];
  logic [7:0] page_b [4];
  logic [7:0] ext23_a;
  logic [3:0] ext23_b;
  logic [7:0][1:0] ext2221_a;
  logic [3:0][1:0] ext2221_b;

  modport regs
  (
    output base_sel, set_a_en, set_b_en, page_a, page_b,
    output ext23_a, ext23_b, ext2221_a, ext2221_b
  );
  modport xlat
  (
    input base_sel, set_a_en, set_b_en, page_a, page_b,
    input ext23_a, ext23_b, ext2221_a, ext2221_b
  );
endinterface : pmw_map_if

// File: logic/pmw_io_dec.sv
// pmw_io_dec: decodes host I/O addresses onto page registers.
// assumes: purely combinational; caller registers what it needs.
`timescale 1ns/10ps
module pmw_io_dec
  import pmw_pkg::*;
(
  // select and address
  input wire logic [3:0] io_sel,
  input wire logic [15:0] io_addr,
  // result
  output logic hit,
  output logic [2:0] page
);

  logic [13:0] base;

  always_comb
  begin
    base = io_base(io_sel);
    // page n sits 2000h above page n-1, so bits 15:13 are the page
    hit = base[13] && (io_addr[12:0] == base[12:0]);
    page = io_addr[15:13];
  end

  // undefined select codes are checked in the clocked parent

endmodule : pmw_io_dec

// File: logic/pmw_xlat.sv
// pmw_xlat: turns a host memory address into the extended address.
// assumes: mem_req/mem_addr come from logic on pclk; answer 1 cycle on.
`timescale 1ns/10ps
module pmw_xlat
  import pmw_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // host memory cycle
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  // mapping state
  pmw_map_if.xlat map,
  // result
  output logic xlat_valid_q,
  output logic xlat_hit_q,
  output logic [23:0] xlat_addr_q
);

  logic [9:0] offs;
  logic [2:0] pa;
  logic [1:0] pb;
  logic in_a;
  logic in_b;
  logic hit;
  logic [9:0] hi;
  logic xlat_valid_d;
  logic xlat_hit_d;
  logic [23:0] xlat_addr_d;

  always_comb
  begin
    offs = mem_addr[23:14] - (SETA_BASE_BLK + {6'h00, map.base_sel});
    in_a = offs < 10'(PAGES_A);
    pa = offs[2:0];
    in_b = mem_addr[23:16] == SETB_BASE_HI;
    pb = mem_addr[15:14];
    hit = 1'b0;
    hi = 10'h000;
    if (in_a)
    begin
      hit = map.set_a_en && map.page_a[pa][PAGE_EN_BIT];
      hi = {map.ext23_a[pa], map.ext2221_a[pa], map.page_a[pa][6:0]};
    end
    else if (in_b)
    begin
      hit = map.set_b_en && map.page_b[pb][PAGE_EN_BIT];
      hi = {map.ext23_b[pb], map.ext2221_b[pb], map.page_b[pb][6:0]};
    end
    xlat_valid_d = mem_req;
    xlat_hit_d = mem_req && hit;
    // untranslated cycles pass the processor address through
    xlat_addr_d = hit ? {hi, mem_addr[13:0]} : mem_addr;
    if (!mem_req)
      xlat_addr_d = xlat_addr_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xlat_valid_q <= 1'b0;
      xlat_hit_q <= 1'b0;
      xlat_addr_q <= 24'h00_0000;
    end
    else if (ce)
    begin
      xlat_valid_q <= xlat_valid_d;
      xlat_hit_q <= xlat_hit_d;
      xlat_addr_q <= xlat_addr_d;
    end
  end

  seta_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mem_req && in_a && !map.set_a_en |=> !xlat_hit_q)
    else $error("set A window hit while region disabled");

  setb_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mem_req && mem_addr[23:16] == 8'h0A && map.set_b_en
    && map.page_b[mem_addr[15:14]][7]
    |=> xlat_hit_q && xlat_addr_q[13:0] == $past(mem_addr[13:0]))
    else $error("fixed set B window did not translate");

endmodule : pmw_xlat

// File: logic/pmw_mapper.sv
// pmw_mapper: paged memory-window mapper, APB registers, page-register
// I/O port and memory translation.
// assumes: host I/O and memory strobes are synchronous to pclk.
//
// Functional notes
// - bit 23 extension per page; high four for set A only.
// - low-page extension copies per set, chosen by set-B control bit 1.
// - set-A base code places eight windows from C0000h in 16K steps.
// - I/O select code gives page-0 base; page n at base plus n*2000h.
// - I/O write to decoded page address stores that window's page byte.
// - page byte bit 7 enables; bits 6 to 0 give A20 to A14.
// - set B fixed at 0A0000h with four 16K pages.
// - set A has pages 0 to 7, set B pages 0 to 3.
// - each set has a whole-region enable besides page enables.
// - set-A global enable low disables every set-A window.
// - bits 22:21 for pages 0 to 3, two bits per page.
// - set-A pages 4 to 7 bits 22:21 written with region bit set.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module pmw_mapper
  import pmw_pkg::*;
#(
  parameter int unsigned AW = 12
)
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host i/o cycles to page registers
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_ack,
  // host memory cycles
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  output logic xlat_valid,
  output logic xlat_hit,
  output logic [23:0] xlat_addr
);

  pmw_map_if map ();

  // register state
  logic seta_en_q, seta_en_d;
  logic [1:0] setb_ctl_q, setb_ctl_d;
  logic [7:0] base_io_q, base_io_d;
  logic [7:0] ext23_a_q, ext23_a_d;
  logic [3:0] ext23_b_q, ext23_b_d;
  logic [7:0] ext_hi_q, ext_hi_d;
  logic [7:0] ext_lo_a_q, ext_lo_a_d;
  logic [7:0] ext_lo_b_q, ext_lo_b_d;
  logic [7:0] page_a_q [8];
  logic [7:0] page_a_d [8];
  logic [7:0] page_b_q [4];
  logic [7:0] page_b_d [4];
  // bus answer
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] io_rdata_q, io_rdata_d;
  logic io_ack_q, io_ack_d;

  logic [9:0] idx;
  logic wr_en;
  logic mapped;
  logic [7:0] rd_byte;
  logic region_a;
  logic dec_hit;
  logic [2:0] dec_page;
  logic io_to_a;

  pmw_io_dec u_dec
  (
    .io_sel(base_io_q[IO_SEL_LSB +: 4]),
    .io_addr(io_addr),
    .hit(dec_hit),
    .page(dec_page)
  );

  pmw_xlat u_xlat
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .map(map.xlat),
    .xlat_valid_q(xlat_valid),
    .xlat_hit_q(xlat_hit),
    .xlat_addr_q(xlat_addr)
  );

  // mapping state seen by the translator
  always_comb
  begin
    map.base_sel = base_io_q[BASE_SEL_LSB +: 4];
    map.set_a_en = seta_en_q;
    map.set_b_en = setb_ctl_q[SETB_EN_BIT];
    map.ext23_a = ext23_a_q;
    map.ext23_b = ext23_b_q;
    map.ext2221_a = {ext_hi_q, ext_lo_a_q};
    map.ext2221_b = ext_lo_b_q;
    for (int i = 0; i < PAGES_A; i++)
      map.page_a[i] = page_a_q[i];
    for (int i = 0; i < PAGES_B; i++)
      map.page_b[i] = page_b_q[i];
  end

  // apb decode and read mux
  always_comb
  begin
    idx = paddr[AW-1:2];
    region_a = setb_ctl_q[SETB_REGION_BIT];
    // one wait state: pready rises on the second access cycle
    wr_en = psel && penable && pready_q && pwrite && pstrb[0];
    mapped = 1'b1;
    rd_byte = RST_BYTE;
    case (idx)
      IDX_ROMCFG: rd_byte = {1'b0, seta_en_q, 6'h00};
      IDX_EXT_HI: rd_byte = ext_hi_q;
      IDX_EXT23: rd_byte = {ext23_a_q[7:4],
                            region_a ? ext23_a_q[3:0] : ext23_b_q};
      IDX_BASEIO: rd_byte = base_io_q;
      IDX_EXT_LO: rd_byte = region_a ? ext_lo_a_q : ext_lo_b_q;
      IDX_SETB_CTL: rd_byte = {6'h00, setb_ctl_q};
      default: mapped = 1'b0;
    endcase
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d = prdata_q;
    if (pready_d)
      prdata_d = (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
  end

  // register next values; I/O writes and APB writes hit disjoint state
  always_comb
  begin
    seta_en_d = seta_en_q;
    setb_ctl_d = setb_ctl_q;
    base_io_d = base_io_q;
    ext23_a_d = ext23_a_q;
    ext23_b_d = ext23_b_q;
    ext_hi_d = ext_hi_q;
    ext_lo_a_d = ext_lo_a_q;
    ext_lo_b_d = ext_lo_b_q;
    if (wr_en)
    begin
      case (idx)
        IDX_ROMCFG: seta_en_d = pwdata[ROMCFG_SETA_EN_BIT];
        // guarded: the high pages belong to set A alone
        IDX_EXT_HI:
          if (region_a)
            ext_hi_d = pwdata[7:0];
        IDX_EXT23:
        begin
          ext23_a_d[7:4] = pwdata[7:4];
          if (region_a)
            ext23_a_d[3:0] = pwdata[3:0];
          else
            ext23_b_d = pwdata[3:0];
        end
        IDX_BASEIO: base_io_d = pwdata[7:0];
        IDX_EXT_LO:
          if (region_a)
            ext_lo_a_d = pwdata[7:0];
          else
            ext_lo_b_d = pwdata[7:0];
        IDX_SETB_CTL: setb_ctl_d = pwdata[1:0];
        default: ;
      endcase
    end
  end

  // page registers over the I/O port
  always_comb
  begin
    // pages 0..3 are shared addresses; the region bit picks the set
    io_to_a = dec_page[2] || setb_ctl_q[SETB_REGION_BIT];
    for (int i = 0; i < PAGES_A; i++)
      page_a_d[i] = page_a_q[i];
    for (int i = 0; i < PAGES_B; i++)
      page_b_d[i] = page_b_q[i];
    if (io_wr && dec_hit)
    begin
      if (io_to_a)
        page_a_d[dec_page] = io_wdata;
      else
        page_b_d[dec_page[1:0]] = io_wdata;
    end
    io_ack_d = (io_wr || io_rd) && dec_hit;
    io_rdata_d = io_rdata_q;
    if (io_rd && dec_hit)
      io_rdata_d = io_to_a ? page_a_q[dec_page] : page_b_q[dec_page[1:0]];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seta_en_q <= 1'b0;
      setb_ctl_q <= 2'h0;
      base_io_q <= RST_BYTE;
      ext23_a_q <= RST_BYTE;
      ext23_b_q <= 4'h0;
      ext_hi_q <= RST_BYTE;
      ext_lo_a_q <= RST_BYTE;
      ext_lo_b_q <= RST_BYTE;
      for (int i = 0; i < PAGES_A; i++)
        page_a_q[i] <= RST_BYTE;
      for (int i = 0; i < PAGES_B; i++)
        page_b_q[i] <= RST_BYTE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      io_rdata_q <= RST_BYTE;
      io_ack_q <= 1'b0;
    end
    else if (ce)
    begin
      seta_en_q <= seta_en_d;
      setb_ctl_q <= setb_ctl_d;
      base_io_q <= base_io_d;
      ext23_a_q <= ext23_a_d;
      ext23_b_q <= ext23_b_d;
      ext_hi_q <= ext_hi_d;
      ext_lo_a_q <= ext_lo_a_d;
      ext_lo_b_q <= ext_lo_b_d;
      for (int i = 0; i < PAGES_A; i++)
        page_a_q[i] <= page_a_d[i];
      for (int i = 0; i < PAGES_B; i++)
        page_b_q[i] <= page_b_d[i];
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      io_rdata_q <= io_rdata_d;
      io_ack_q <= io_ack_d;
    end
  end

  always_comb
  begin
    prdata = prdata_q;
    pready = pready_q;
    pslverr = pslverr_q;
    io_rdata = io_rdata_q;
    io_ack = io_ack_q;
  end

  // checks
  sequence apb_wr_to(logic [9:0] which);
    ce && psel && penable && pready_q && pwrite && pstrb[0]
    && paddr[AW-1:2] == which;
  endsequence

  sequence io_page_wr;
    ce && io_wr && dec_hit;
  endsequence

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && !pready_q |=> pready_q)
    else $error("apb access not answered after one wait state");

  ext23_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr_to(IDX_EXT23) |=> ext23_a_q[7:4] == $past(pwdata[7:4]))
    else $error("high bit-23 extension not stored");

  region_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr_to(IDX_EXT23) ##0 !setb_ctl_q[1]
    |=> ext23_b_q == $past(pwdata[3:0])
    && ext23_a_q[3:0] == $past(ext23_a_q[3:0]))
    else $error("low bit-23 write reached the wrong copy");

  ext_hi_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr_to(IDX_EXT_HI) ##0 !setb_ctl_q[1] |=> $stable(ext_hi_q))
    else $error("high-page extension written with region bit clear");

  page_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    io_page_wr ##0 (dec_page[2] || setb_ctl_q[1])
    |=> page_a_q[$past(dec_page)] == $past(io_wdata))
    else $error("page register write lost");

  io_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (io_wr || io_rd) && !dec_hit |=> !io_ack_q)
    else $error("i/o cycle acknowledged at undecoded address");

  bad_code_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ce && (io_wr || io_rd) && !(base_io_q[3:0] inside {4'h0, 4'h1, 4'h5,
    4'h6, 4'hA, 4'hB, 4'hE}) |=> !io_ack_q)
    else $error("page decode active for undefined select code");

  xlat_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mem_req |=> xlat_valid
    && xlat_addr[13:0] == $past(mem_addr[13:0]))
    else $error("offset bits not passed through");

  seta_page_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mem_req && seta_en_q
    && mem_addr[23:14] == 10'h030 + {6'h00, base_io_q[7:4]}
    && page_a_q[0][7]
    |=> xlat_hit && xlat_addr[23:14] == {$past(ext23_a_q[0]),
    $past(ext_lo_a_q[1:0]), $past(page_a_q[0][6:0])})
    else $error("set A page 0 not translated at its base");

endmodule : pmw_mapper

// File: test/pmw_host_model.sv
// pmw_host_model: host processor issuing page-register i/o cycles and
// memory cycles. assumes: the bench calls its tasks, one at a time.
`timescale 1ns/10ps
module pmw_host_model
(
  // clock
  input wire logic pclk,
  // i/o cycles
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_ack,
  // memory cycles
  output logic mem_req,
  output logic [23:0] mem_addr,
  input wire logic xlat_valid,
  input wire logic xlat_hit,
  input wire logic [23:0] xlat_addr
);
  initial
  begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    mem_req = 1'b0;
    mem_addr = 24'h00_0000;
  end

  // released address and data lines show the inverse, so a stale value never matches
  task automatic io_cycle(input logic wr, input logic [15:0] a,
    input logic [7:0] d, output logic ack, output logic [7:0] rd);
    @(posedge pclk);
    io_wr <= wr;
    io_rd <= ~wr;
    io_addr <= a;
    io_wdata <= d;
    @(posedge pclk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    // the answer stands in the cycle after the request edge
    @(posedge pclk);
    ack = io_ack;
    rd = io_rdata;
  endtask : io_cycle

  task automatic mem_cycle(input logic [23:0] a, output logic v,
    output logic h, output logic [23:0] x);
    @(posedge pclk);
    mem_req <= 1'b1;
    mem_addr <= a;
    @(posedge pclk);
    mem_req <= 1'b0;
    mem_addr <= ~a;
    @(posedge pclk);
    v = xlat_valid;
    h = xlat_hit;
    x = xlat_addr;
  endtask : mem_cycle
endmodule : pmw_host_model

// File: test/test_paged_memory_window_mapper.sv
// test_paged_memory_window_mapper: self-checking bench for pmw_mapper.
// assumes: pmw_host_model stands in for the host; ce and pstrb are tied.
`timescale 1ns/10ps
module test_paged_memory_window_mapper;
  import pmw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic io_wr, io_rd, io_ack, mem_req, xlat_valid, xlat_hit;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, x, e23a;
  logic [23:0] mem_addr, xlat_addr;
  logic [3:0] base, e23b;
  logic [7:0] pa [8];
  logic [7:0] pb [4];
  logic [15:0] e21a;
  logic [7:0] e21b;
  logic sa_en, sb_en;
  int err_total, tests_run;
  logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'hA, 4'hB, 4'hE};
  logic [15:0] iob [7] = '{16'h0208, 16'h0218, 16'h0258, 16'h0268,
    16'h02A8, 16'h02B8, 16'h02E8};
  logic [9:0] ridx [6] = '{IDX_ROMCFG, IDX_EXT_HI, IDX_EXT23, IDX_BASEIO,
    IDX_EXT_LO, IDX_SETB_CTL};

  pmw_mapper #(.AW(12)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
    .mem_req(mem_req), .mem_addr(mem_addr), .xlat_valid(xlat_valid),
    .xlat_hit(xlat_hit), .xlat_addr(xlat_addr));
  pmw_host_model host (.pclk(pclk), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_ack(io_ack), .mem_req(mem_req), .mem_addr(mem_addr),
    .xlat_valid(xlat_valid), .xlat_hit(xlat_hit), .xlat_addr(xlat_addr));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t data got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_xl(input logic [25:0] got, input logic [25:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t xlat got %h exp %h", $time, got, exp);
    end
  endtask : chk_xl

  task automatic apb(input logic wr, input logic [9:0] idx,
    input logic [7:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] ed,
    input logic eerr);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk_reg(r, {24'h00_0000, ed});
    chk_reg({31'h0000_0000, e}, {31'h0000_0000, eerr});
  endtask : rdchk

  task automatic io_chk(input logic w, input logic [15:0] a,
    input logic [7:0] d, input logic eack);
    logic ack;
    logic [7:0] rd;
    host.io_cycle(w, a, d, ack, rd);
    chk_reg({31'h0000_0000, ack}, {31'h0000_0000, eack});
    if (!w)
      chk_reg({24'h00_0000, rd}, {24'h00_0000, d});
  endtask : io_chk

  function automatic logic [24:0] expect_x(input logic [23:0] a);
    logic [9:0] off;
    logic [7:0] pg;
    off = a[23:14] - (10'h030 + {6'h00, base});
    pg = pa[off[2:0]];
    if (sa_en && off < 10'h008 && pg[7])
      return {1'b1, e23a[off[2:0]], e21a[2*off[2:0] +: 2], pg[6:0], a[13:0]};
    pg = pb[a[15:14]];
    if (sb_en && a[23:16] == 8'h0A && pg[7])
      return {1'b1, e23b[a[15:14]], e21b[2*a[15:14] +: 2], pg[6:0], a[13:0]};
    return {1'b0, a};
  endfunction : expect_x

  task automatic mem_chk(input logic [23:0] a);
    logic v, h;
    logic [23:0] t;
    host.mem_cycle(a, v, h, t);
    chk_xl({v, h, t}, {1'b1, expect_x(a)});
  endtask : mem_chk

  task automatic sweep();
    for (int p = 0; p < 8; p++)
      mem_chk({10'h030 + {6'h00, base} + 10'(p), 14'($urandom)});
    for (int p = 0; p < 4; p++)
      mem_chk({8'h0A, 2'(p), 14'($urandom)});
    mem_chk({10'h02F + {6'h00, base}, 14'h3FFF});
    mem_chk({10'h038 + {6'h00, base}, 14'h0000});
    repeat (6)
      mem_chk(24'($urandom));
  endtask : sweep

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    err_total = 0;
    tests_run = 0;
    sa_en = 1'b0;
    sb_en = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    x = 8'($urandom(32'h0e35));
    foreach (ridx[i])
      rdchk(ridx[i], 8'h00, 1'b0);
    rdchk(10'h000, 8'h00, 1'b1);
    wr(IDX_SETB_CTL, 8'h02);
    base = 4'($urandom);
    for (int i = 0; i < 7; i++)
    begin
      wr(IDX_BASEIO, {base, codes[i]});
      x = 8'($urandom) & 8'h7F;
      io_chk(1'b1, iob[i] + 16'(i * 16'h2000), x, 1'b1);
      io_chk(1'b0, iob[i] + 16'(i * 16'h2000), x, 1'b1);
    end
    wr(IDX_BASEIO, {base, 4'h2});
    io_chk(1'b1, 16'h0208, 8'h55, 1'b0);
    wr(IDX_BASEIO, {base, 4'h0});
    e23a = 8'($urandom);
    wr(IDX_EXT23, e23a);
    e21a = 16'($urandom);
    wr(IDX_EXT_LO, e21a[7:0]);
    wr(IDX_EXT_HI, e21a[15:8]);
    for (int p = 0; p < 8; p++)
    begin
      pa[p] = 8'($urandom);
      io_chk(1'b1, 16'h0208 + 16'(p * 16'h2000), pa[p], 1'b1);
    end
    wr(IDX_SETB_CTL, 8'h00);
    x = 8'($urandom);
    wr(IDX_EXT23, x);
    e23a[7:4] = x[7:4];
    e23b = x[3:0];
    e21b = 8'($urandom);
    wr(IDX_EXT_LO, e21b);
    wr(IDX_EXT_HI, ~e21a[15:8]);
    rdchk(IDX_EXT_HI, e21a[15:8], 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      pb[p] = 8'($urandom) | 8'h80;
      io_chk(1'b1, 16'h0208 + 16'(p * 16'h2000), pb[p], 1'b1);
    end
    rdchk(IDX_EXT23, {e23a[7:4], e23b}, 1'b0);
    wr(IDX_SETB_CTL, 8'h03);
    sb_en = 1'b1;
    rdchk(IDX_EXT23, e23a, 1'b0);
    rdchk(IDX_EXT_LO, e21a[7:0], 1'b0);
    sweep();
    wr(IDX_ROMCFG, 8'h40);
    sa_en = 1'b1;
    sweep();
    wr(IDX_SETB_CTL, 8'h02);
    sb_en = 1'b0;
    sweep();
    wr(IDX_ROMCFG, 8'h00);
    sa_en = 1'b0;
    sweep();
    tally_and_finish();
  end
endmodule : test_paged_memory_window_mapper
